// [design/pin_edge_sync.sv]
// Two-stage synchroniser and edge detector for the timer input pins
`timescale 1ns/10ps
module pin_edge_sync #(
	parameter int N = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [N-1:0] pins,
	pin_events_if.src ev
);

	typedef struct packed {
		logic [N-1:0] meta;
		logic [N-1:0] sync;
		logic [N-1:0] last;
	} sync_t;

	sync_t s;
	sync_t next_s;

	always_comb begin
		next_s = s;
		next_s.meta = pins;
		next_s.sync = s.meta;
		next_s.last = s.sync;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Only the second stage and its delayed copy are compared
	assign ev.rise = s.sync & ~s.last;
	assign ev.fall = ~s.sync & s.last;

endmodule : pin_edge_sync

// [design/pin_events_if.sv]
// Edge events of the synchronised timer pins
`timescale 1ns/10ps
interface pin_events_if #(parameter int N = 3);
	logic [N-1:0] rise;
	logic [N-1:0] fall;
	modport src (output rise, output fall);
	modport dst (input rise, input fall);
endinterface : pin_events_if

// [design/standard_timer.sv]
// Standard timer: PWM, single pulse and capture modes behind APB
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps

module standard_timer (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic external_trigger_pin,
	input wire logic capture_pin_0,
	input wire logic capture_pin_1,
	output logic timer_out,
	output logic timer_out_en,
	output logic timer_request
);

	// ******************************************************************
	// State
	// ******************************************************************
	typedef struct packed {
		logic [2:0] clk_sel;
		logic counter_run;
		logic [2:0] period_compare_code;
		logic [1:0] mode_select;
		logic [1:0] pin_function_select;
		logic output_initial_level;
		logic output_invert;
		logic duty_period_swap;
		logic clear_source_select;
		logic [timer_pkg::CNT_W-1:0] compare_a_value;
		logic [timer_pkg::CNT_W-1:0] counter;
		logic run_prev;
		logic [1:0] flags;
		logic request;
		logic [timer_pkg::DIV_W-1:0] div;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic out;
		logic out_en;
	} state_t;

	state_t s;
	state_t next_s;

	pin_events_if #(.N(timer_pkg::PIN_N)) ev ();

	pin_edge_sync #(.N(timer_pkg::PIN_N)) sync_u (
		.pclk(pclk),
		.presetn(presetn),
		.pins({capture_pin_1, capture_pin_0, external_trigger_pin}),
		.ev(ev)
	);

	// ******************************************************************
	// Next state
	// ******************************************************************
	always_comb begin
		logic tick;
		logic is_pwm;
		logic is_pulse;
		logic is_cap;
		logic run_rise;
		logic trig_edge;
		logic cap_edge;
		logic [10:0] count_plus;
		logic [10:0] code_len;
		logic [10:0] period_len;
		logic [10:0] duty_len;
		logic a_match;
		logic p_match;
		logic active;
		logic mapped;
		logic [31:0] rd;
		logic [1:0] clr;
		logic [1:0] set;
		tick = 1'b0;
		is_pwm = 1'b0;
		is_pulse = 1'b0;
		is_cap = 1'b0;
		run_rise = 1'b0;
		trig_edge = 1'b0;
		cap_edge = 1'b0;
		count_plus = 11'h000;
		code_len = 11'h000;
		period_len = 11'h000;
		duty_len = 11'h000;
		a_match = 1'b0;
		p_match = 1'b0;
		active = 1'b0;
		mapped = 1'b0;
		rd = 32'h0000_0000;
		clr = 2'h0;
		set = 2'h0;
		next_s = s;

		next_s.div = s.div + 7'h01;

		// Slow rates are enables from one shared free-running divider
		case (s.clk_sel)
			timer_pkg::CK_DIV4: tick = (s.div & timer_pkg::DIV4_MASK) ==
				timer_pkg::DIV4_MASK;
			timer_pkg::CK_SYS: tick = 1'b1;
			timer_pkg::CK_DIV16: tick = (s.div & timer_pkg::DIV16_MASK) ==
				timer_pkg::DIV16_MASK;
			timer_pkg::CK_DIV64: tick = (s.div & timer_pkg::DIV64_MASK) ==
				timer_pkg::DIV64_MASK;
			timer_pkg::CK_BASE: tick = (s.div & timer_pkg::BASE_MASK) ==
				timer_pkg::BASE_MASK;
			timer_pkg::CK_EXT_RISE: tick = ev.rise[timer_pkg::TRIG_IDX];
			timer_pkg::CK_EXT_FALL: tick = ev.fall[timer_pkg::TRIG_IDX];
			default: tick = 1'b0;
		endcase

		is_pwm = (s.mode_select == timer_pkg::MODE_PWM) &&
			(s.pin_function_select != timer_pkg::PIN_PULSE);
		is_pulse = (s.mode_select == timer_pkg::MODE_PWM) &&
			(s.pin_function_select == timer_pkg::PIN_PULSE);
		is_cap = s.mode_select == timer_pkg::MODE_CAPTURE;

		// ************************************************************
		// APB slave, one wait state: answer prepared, then committed
		// ************************************************************
		if (s.clk_sel == timer_pkg::CK_EXT_FALL) begin
			trig_edge = ev.fall[timer_pkg::TRIG_IDX];
		end else begin
			trig_edge = ev.rise[timer_pkg::TRIG_IDX];
		end

		mapped = 1'b1;
		if (paddr == timer_pkg::CTRL0_OFF) begin
			rd[timer_pkg::CLKSEL_LSB +: 3] = s.clk_sel;
			rd[timer_pkg::RUN_BIT] = s.counter_run;
			rd[timer_pkg::PCODE_LSB +: 3] = s.period_compare_code;
		end else if (paddr == timer_pkg::CTRL1_OFF) begin
			rd[timer_pkg::MODE_LSB +: 2] = s.mode_select;
			rd[timer_pkg::PINFN_LSB +: 2] = s.pin_function_select;
			rd[timer_pkg::INIT_BIT] = s.output_initial_level;
			rd[timer_pkg::INV_BIT] = s.output_invert;
			rd[timer_pkg::SWAP_BIT] = s.duty_period_swap;
			rd[timer_pkg::CCLR_BIT] = s.clear_source_select;
		end else if (paddr == timer_pkg::COUNT_OFF) begin
			rd[timer_pkg::CNT_W-1:0] = s.counter;
		end else if (paddr == timer_pkg::CMPA_OFF) begin
			rd[timer_pkg::CNT_W-1:0] = s.compare_a_value;
		end else if (paddr == timer_pkg::STATUS_OFF) begin
			rd[1:0] = s.flags;
		end else begin
			mapped = 1'b0;
		end

		next_s.pready = 1'b0;
		if (psel && penable && !s.pready) begin
			next_s.pready = 1'b1;
			next_s.pslverr = !mapped;
			next_s.prdata = pwrite ? 32'h0000_0000 : rd;
		end else if (psel && penable && s.pready && pwrite && mapped) begin
			// Writes take effect only at the completing edge
			if (paddr == timer_pkg::CTRL0_OFF) begin
				next_s.clk_sel = pwdata[timer_pkg::CLKSEL_LSB +: 3];
				next_s.counter_run = pwdata[timer_pkg::RUN_BIT];
				next_s.period_compare_code =
					pwdata[timer_pkg::PCODE_LSB +: 3];
			end else if (paddr == timer_pkg::CTRL1_OFF) begin
				next_s.mode_select = pwdata[timer_pkg::MODE_LSB +: 2];
				next_s.pin_function_select =
					pwdata[timer_pkg::PINFN_LSB +: 2];
				next_s.output_initial_level = pwdata[timer_pkg::INIT_BIT];
				next_s.output_invert = pwdata[timer_pkg::INV_BIT];
				next_s.duty_period_swap = pwdata[timer_pkg::SWAP_BIT];
				next_s.clear_source_select = pwdata[timer_pkg::CCLR_BIT];
			end else if (paddr == timer_pkg::CMPA_OFF) begin
				next_s.compare_a_value = pwdata[timer_pkg::CNT_W-1:0];
			end else if (paddr == timer_pkg::STATUS_OFF) begin
				clr = pwdata[1:0];
			end
		end

		// ************************************************************
		// Counter and comparators
		// ************************************************************
		run_rise = s.counter_run && !s.run_prev;
		next_s.run_prev = s.counter_run;
		count_plus = {1'b0, s.counter} + 11'h001;
		if (s.period_compare_code == timer_pkg::PCODE_FULL) begin
			code_len = timer_pkg::FULL_COUNT;
		end else begin
			code_len = {1'b0, s.period_compare_code, 7'h00};
		end
		// Clear source select is never consulted in these modes
		if (is_pwm && s.duty_period_swap) begin
			period_len = {1'b0, s.compare_a_value};
			duty_len = code_len;
		end else begin
			period_len = code_len;
			duty_len = {1'b0, s.compare_a_value};
		end
		// A residual count must not match in the cycle that clears it
		a_match = s.counter_run && tick && !run_rise &&
			(count_plus == {1'b0, s.compare_a_value});
		p_match = s.counter_run && tick && !run_rise &&
			(count_plus == code_len);

		if (run_rise) begin
			next_s.counter = '0;
		end else if (s.counter_run && tick) begin
			next_s.counter = count_plus[timer_pkg::CNT_W-1:0];
			if (is_pwm) begin
				if (count_plus >= period_len) begin
					next_s.counter = '0;
				end
			end else if (is_cap) begin
				if (p_match) begin
					next_s.counter = '0;
				end
			end else if (!is_pulse && p_match) begin
				next_s.counter = '0;
			end
		end

		if (is_pwm) begin
			set[timer_pkg::FLAG_A_BIT] = a_match;
			set[timer_pkg::FLAG_P_BIT] = p_match;
		end else if (is_pulse) begin
			// Pulse width is set by compare A alone
			set[timer_pkg::FLAG_A_BIT] = a_match;
			if (a_match) begin
				next_s.counter_run = 1'b0;
			end
		end else if (is_cap) begin
			set[timer_pkg::FLAG_P_BIT] = p_match;
		end else begin
			set[timer_pkg::FLAG_A_BIT] = a_match;
			set[timer_pkg::FLAG_P_BIT] = p_match;
		end

		// In single pulse mode only, the trigger pin acts as a software write of one to the run bit
		if (is_pulse && trig_edge) begin
			next_s.counter_run = 1'b1;
		end

		// Capture pins are watched whatever else drives the shared pin
		case (s.pin_function_select)
			timer_pkg::CAP_RISE: cap_edge =
				|ev.rise[timer_pkg::CAP1_IDX:timer_pkg::CAP0_IDX];
			timer_pkg::CAP_FALL: cap_edge =
				|ev.fall[timer_pkg::CAP1_IDX:timer_pkg::CAP0_IDX];
			timer_pkg::CAP_BOTH: cap_edge =
				|ev.rise[timer_pkg::CAP1_IDX:timer_pkg::CAP0_IDX] ||
				|ev.fall[timer_pkg::CAP1_IDX:timer_pkg::CAP0_IDX];
			default: cap_edge = 1'b0;
		endcase
		if (is_cap && cap_edge) begin
			next_s.compare_a_value = s.counter;
			set[timer_pkg::FLAG_A_BIT] = 1'b1;
		end

		// An event in the clearing cycle survives the clear
		next_s.flags = (s.flags & ~clr) | set;
		next_s.request = |next_s.flags;

		// ************************************************************
		// Output pin
		// ************************************************************
		// Counter below duty; duty at or past period stays active
		active = {1'b0, s.counter} < duty_len;
		next_s.out_en = 1'b0;
		next_s.out = 1'b0;
		if (is_pwm) begin
			next_s.out_en = 1'b1;
			case (s.pin_function_select)
				timer_pkg::PIN_INACTIVE: active = 1'b0;
				timer_pkg::PIN_ACTIVE: active = 1'b1;
				default: active = active;
			endcase
			next_s.out = (active ~^ s.output_initial_level) ^
				s.output_invert;
		end else if (is_pulse) begin
			next_s.out_en = 1'b1;
			// Leading edge with the run bit, trailing edge when it drops
			next_s.out = (s.counter_run ~^ s.output_initial_level) ^
				s.output_invert;
		end else if (is_cap) begin
			next_s.out_en = 1'b0;
		end
		// Compare and timer modes only count and set flags; pin left off
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ******************************************************************
	// Outputs
	// ******************************************************************
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign timer_out = s.out;
	assign timer_out_en = s.out_en;
	assign timer_request = s.request;

endmodule : standard_timer

// [design/timer_pkg.sv]
// Shared constants of the standard timer: offsets, fields, codes, counts
package timer_pkg;

	// ******************************************************************
	// Register offsets (byte addresses, one 32-bit word each)
	// ******************************************************************
	localparam logic [11:0] CTRL0_OFF = 12'h000;
	localparam logic [11:0] CTRL1_OFF = 12'h004;
	localparam logic [11:0] COUNT_OFF = 12'h008;
	localparam logic [11:0] CMPA_OFF = 12'h00c;
	localparam logic [11:0] STATUS_OFF = 12'h010;

	// ******************************************************************
	// Field positions
	// ******************************************************************
	localparam int CLKSEL_LSB = 4;
	localparam int RUN_BIT = 3;
	localparam int PCODE_LSB = 0;
	localparam int MODE_LSB = 6;
	localparam int PINFN_LSB = 4;
	localparam int INIT_BIT = 3;
	localparam int INV_BIT = 2;
	localparam int SWAP_BIT = 1;
	localparam int CCLR_BIT = 0;
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;

	// ******************************************************************
	// Mode, pin function and clock select codes
	// ******************************************************************
	localparam logic [1:0] MODE_COMPARE = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TIMER = 2'h3;
	localparam logic [1:0] PIN_INACTIVE = 2'h0;
	localparam logic [1:0] PIN_ACTIVE = 2'h1;
	localparam logic [1:0] PIN_PWM = 2'h2;
	localparam logic [1:0] PIN_PULSE = 2'h3;
	localparam logic [1:0] CAP_RISE = 2'h0;
	localparam logic [1:0] CAP_FALL = 2'h1;
	localparam logic [1:0] CAP_BOTH = 2'h2;
	localparam logic [2:0] CK_DIV4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_DIV16 = 3'h2;
	localparam logic [2:0] CK_DIV64 = 3'h3;
	localparam logic [2:0] CK_BASE = 3'h4;
	localparam logic [2:0] CK_EXT_RISE = 3'h6;
	localparam logic [2:0] CK_EXT_FALL = 3'h7;

	// ******************************************************************
	// Divider, counter and pin constants
	// ******************************************************************
	localparam int DIV_W = 7;
	localparam logic [6:0] DIV4_MASK = 7'h03;
	localparam logic [6:0] DIV16_MASK = 7'h0f;
	localparam logic [6:0] DIV64_MASK = 7'h3f;
	localparam logic [6:0] BASE_MASK = 7'h7f;
	localparam int CNT_W = 10;
	localparam logic [10:0] FULL_COUNT = 11'h400;
	localparam logic [2:0] PCODE_FULL = 3'h0;
	localparam int PIN_N = 3;
	localparam int TRIG_IDX = 0;
	localparam int CAP0_IDX = 1;
	localparam int CAP1_IDX = 2;
	localparam logic [PIN_N-1:0] PIN_RST = 3'h0;

endpackage : timer_pkg

// [dv/pin_model.sv]
// Far-side model: trigger and capture pins, output pin watcher
`timescale 1ns/10ps
module pin_model (
	input wire logic pclk,
	input wire logic timer_out,
	output logic [2:0] pins
);
	initial pins = 3'h0;

	// Hold sets how many cycles the pin stays high; one cycle is the shortest
	task automatic toggle(input int idx, input int hold);
		@(posedge pclk);
		pins[idx] <= 1'b1;
		repeat (hold) @(posedge pclk);
		pins[idx] <= 1'b0;
	endtask : toggle

	task automatic measure(input int win, output int cnt);
		cnt = 0;
		repeat (win) begin
			@(posedge pclk);
			if (timer_out === 1'b1) begin
				cnt++;
			end
		end
	endtask : measure
endmodule : pin_model

// [dv/standard_timer_test.sv]
// Self-checking bench of the standard timer
`timescale 1ns/10ps
module standard_timer_test;
	localparam logic [11:0] ctl0 = timer_pkg::CTRL0_OFF;
	localparam logic [11:0] ctl1 = timer_pkg::CTRL1_OFF;
	localparam logic [11:0] cnt = timer_pkg::COUNT_OFF;
	localparam logic [11:0] cmpa = timer_pkg::CMPA_OFF;
	localparam logic [11:0] stat = timer_pkg::STATUS_OFF;
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, c, s;
	logic pready, pslverr, timer_out, timer_out_en, timer_request;
	logic [2:0] pins;
	int fails = 0;
	int num_checks = 0;
	standard_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_trigger_pin(pins[0]), .capture_pin_0(pins[1]),
		.capture_pin_1(pins[2]), .timer_out(timer_out),
		.timer_out_en(timer_out_en), .timer_request(timer_request));
	pin_model pm (.pclk(pclk), .timer_out(timer_out), .pins(pins));

	// ******************************************************************
	// Shared tasks
	// ******************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic [11:0] ad, input logic w,
		input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		check(pready, 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : bus

	// Two whole periods are counted, so the phase does not matter
	task automatic pwm_run(input logic [7:0] m, input logic [9:0] ca,
		input int win, input int exp);
		int cn;
		bus(ctl0, 1'b1, 32'h10);
		bus(ctl1, 1'b1, {24'h0, m});
		bus(cmpa, 1'b1, {22'h0, ca});
		bus(ctl0, 1'b1, 32'h19);
		repeat (10) @(posedge pclk);
		pm.measure(win, cn);
		check(cn, exp);
	endtask : pwm_run

	// ******************************************************************
	// Scenarios
	// ******************************************************************
	task automatic t_regs();
		for (int i = 0; i < 5; i++) begin
			bus(12'(4 * i), 1'b0, 32'h0);
			check(q, 32'h0);
			check(err, 1'b0);
		end
		bus(cmpa, 1'b1, 32'h155);
		bus(cmpa, 1'b0, 32'h0);
		check(q, 32'h155);
		bus(cnt, 1'b1, 32'h5);
		bus(cnt, 1'b0, 32'h0);
		check(q, 32'h0);
		bus(12'h020, 1'b0, 32'h0);
		check(q, 32'h0);
		check(err, 1'b1);
	endtask : t_regs

	task automatic t_pwm();
		pwm_run(8'ha8, 10'd32, 256, 64);
		pwm_run(8'hab, 10'd200, 400, 256);
		pwm_run(8'ha8, 10'h3ff, 256, 256);
		pwm_run(8'h88, 10'd32, 256, 0);
		bus(stat, 1'b1, 32'h3);
		repeat (200) @(posedge pclk);
		bus(stat, 1'b0, 32'h0);
		check(q[1], 1'b1);
		pwm_run(8'h98, 10'd32, 256, 256);
	endtask : t_pwm

	task automatic t_pulse();
		int cn;
		bus(ctl0, 1'b1, 32'h11);
		bus(ctl1, 1'b1, 32'hbb);
		bus(cmpa, 1'b1, 32'd200);
		bus(stat, 1'b1, 32'h3);
		pm.toggle(0, 1);
		pm.measure(400, cn);
		// One run-rise clear cycle, then 200 ticks to the compare A match
		check(cn, 201);
		bus(ctl0, 1'b0, 32'h0);
		check(q[3], 1'b0);
		bus(stat, 1'b0, 32'h0);
		check(q[0], 1'b1);
		check(timer_request, 1'b1);
		bus(cnt, 1'b0, 32'h0);
		check(q != 32'h0, 1'b1);
		fork
			pm.measure(40, cn);
			begin
				bus(ctl0, 1'b1, 32'h19);
				bus(cnt, 1'b0, 32'h0);
				check(q < 32'd8, 1'b1);
				bus(ctl0, 1'b1, 32'h11);
			end
		join
		check(cn > 0 && cn < 20, 1'b1);
	endtask : t_pulse

	task automatic t_cap();
		bus(ctl0, 1'b1, 32'h10);
		bus(ctl1, 1'b1, 32'h40);
		bus(ctl0, 1'b1, 32'h18);
		for (int i = 0; i < 3; i++) begin
			bus(ctl1, 1'b1, {24'h0, 2'h1, i[1:0], 4'h0});
			bus(stat, 1'b1, 32'h3);
			bus(cnt, 1'b0, 32'h0);
			s = q;
			pm.toggle(1 + i % 2, 4);
			repeat (6) @(posedge pclk);
			bus(cmpa, 1'b0, 32'h0);
			c = q;
			bus(cnt, 1'b0, 32'h0);
			check(c >= s && c <= q, 1'b1);
			check(q > s + 32'd10, 1'b1);
			bus(stat, 1'b0, 32'h0);
			check(q[0], 1'b1);
			check(timer_out_en, 1'b0);
		end
		bus(ctl1, 1'b1, 32'h70);
		bus(stat, 1'b1, 32'h3);
		pm.toggle(2, 4);
		repeat (6) @(posedge pclk);
		bus(cmpa, 1'b0, 32'h0);
		check(q, c);
		bus(stat, 1'b0, 32'h0);
		check(q[0], 1'b0);
		bus(ctl0, 1'b1, 32'h11);
		bus(ctl0, 1'b1, 32'h19);
		repeat (300) @(posedge pclk);
		bus(cnt, 1'b0, 32'h0);
		check(q < 32'd128, 1'b1);
		bus(stat, 1'b0, 32'h0);
		check(q[1], 1'b1);
		bus(ctl0, 1'b1, 32'h10);
		bus(ctl0, 1'b1, 32'h18);
		repeat (900) @(posedge pclk);
		bus(ctl0, 1'b1, 32'h10);
		bus(cnt, 1'b0, 32'h0);
		s = q;
		check(s > 32'd880 && s < 32'd1024, 1'b1);
		repeat (20) @(posedge pclk);
		bus(cnt, 1'b0, 32'h0);
		check(q, s);
		// Divided timer clock: one count per four cycles, phase unknown
		bus(ctl0, 1'b1, 32'h08);
		repeat (400) @(posedge pclk);
		bus(ctl0, 1'b1, 32'h00);
		bus(cnt, 1'b0, 32'h0);
		check(q >= 32'd100 && q <= 32'd101, 1'b1);
	endtask : t_cap

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_pwm();
		t_pulse();
		t_cap();
		end_of_test();
	end

	// The scenarios need about 4100 cycles; this leaves ample margin
	initial begin
		#200us;
		fails++;
		end_of_test();
	end
endmodule : standard_timer_test

// [dv/timer_monitor.sv]
// Port checker of the standard timer
`timescale 1ns/10ps
module timer_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic external_trigger_pin,
	input wire logic capture_pin_0,
	input wire logic capture_pin_1,
	input wire logic timer_out,
	input wire logic timer_out_en,
	input wire logic timer_request
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] c1;
	logic run;
	logic [2:0] age;
	logic wr;
	logic clr;
	logic act;
	logic ok;
	logic m_cap;
	logic m_pwm;
	assign wr = psel && penable && pready && pwrite;
	assign clr = wr && paddr == timer_pkg::STATUS_OFF && pwdata[1:0] != 2'h0;
	assign act = c1[3] ^ c1[2];
	// Outputs lag a control write, so checks wait until it has settled
	assign ok = age > 3'h3;
	assign m_cap = c1[7:6] == timer_pkg::MODE_CAPTURE;
	assign m_pwm = c1[7:6] == timer_pkg::MODE_PWM;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c1 <= 8'h00;
			run <= 1'b0;
			age <= 3'h0;
		end else if (wr && paddr < 12'h008) begin
			if (paddr == timer_pkg::CTRL1_OFF) begin
				c1 <= pwdata[7:0];
			end else begin
				run <= pwdata[3];
			end
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	sequence setup_access;
		psel && !penable ##1 psel && penable;
	endsequence
	chk_one_wait: assert property (setup_access |-> !pready ##1 pready)
		else $error("wait state wrong");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_err_unmapped: assert property (
		pready && paddr > timer_pkg::STATUS_OFF |-> pslverr)
		else $error("no error on unmapped");
	chk_cap_quiet: assert property (m_cap && ok |-> !timer_out_en)
		else $error("capture drives pin");
	chk_pwm_drive: assert property (m_pwm && ok |-> timer_out_en)
		else $error("pwm pin not driven");
	chk_forced_level: assert property (
		m_pwm && !c1[5] && run && ok |-> timer_out == (c1[4] ~^ act))
		else $error("forced level wrong");
	chk_trig_pulse: assert property (
		m_pwm && c1[5:4] == timer_pkg::PIN_PULSE && ok
		&& $rose(external_trigger_pin) |-> ##[3:6] timer_out == act)
		else $error("trigger gave no pulse");
	chk_cap_req: assert property (
		m_cap && c1[5:4] == timer_pkg::CAP_RISE && ok
		&& $rose(capture_pin_0) |-> ##[2:6] timer_request)
		else $error("capture gave no request");
	chk_req_hold: assert property (
		timer_request && !clr && !$past(clr) |=> timer_request)
		else $error("request dropped");
endmodule : timer_monitor

bind standard_timer timer_monitor mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.external_trigger_pin(external_trigger_pin),
	.capture_pin_0(capture_pin_0), .capture_pin_1(capture_pin_1),
	.timer_out(timer_out), .timer_out_en(timer_out_en),
	.timer_request(timer_request));
